//--- rtl/dac_data_pkg.sv
// Constants for the converter data and calibration register block.
// Assumes an 8-bit register port with byte offsets as below.
package dac_data_pkg;
    localparam int          ADDR_WIDTH      = 5;
    localparam int          DATA_WIDTH      = 8;
    localparam int          VALUE_WIDTH     = 12;
    localparam int          CHAN_COUNT      = 2;
    localparam logic [4:0]  OFS_CONTROL_C   = 5'h02;
    localparam logic [4:0]  OFS_STATUS      = 5'h05;
    localparam logic [4:0]  OFS_IRQ_MASK    = 5'h06;
    localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h07;
    localparam logic [4:0]  OFS_GAIN_TRIM   = 5'h08;
    localparam logic [4:0]  OFS_OFFSET_TRIM = 5'h09;
    localparam logic [4:0]  OFS_CHAN0_LOW   = 5'h18;
    localparam logic [4:0]  OFS_CHAN0_HIGH  = 5'h19;
    localparam logic [4:0]  OFS_CHAN1_LOW   = 5'h1a;
    localparam logic [4:0]  OFS_CHAN1_HIGH  = 5'h1b;
    localparam int          LEFT_ALIGN_BIT  = 0;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [11:0] VALUE_RESET     = 12'h000;
    localparam logic [1:0]  FLAGS_RESET     = 2'h0;
endpackage : dac_data_pkg

//--- rtl/dac_data_calibration_regs.sv
// Data, empty-flag and calibration registers of a two-channel 12-bit converter.
// Assumes a single-cycle master on clk_sys; read data appear the cycle after the strobe.
//
// Summary of operation
// RQ1: Channel 0 empty flag is set while no value is pending; the code clears it at reset and sets it only on a take.
// RQ2: A write while the flag is clear overwrites the pending value.
// RQ3: Each empty flag drives that channel's DMA request directly.
// RQ4: Each channel holds a 12-bit value built from high and low bytes.
// RQ5: Right layout: low byte holds bits 7:0, high nibble bits 11:8.
// RQ6: The left-align control switches both channels to left layout.
// RQ7: Left layout: high byte holds bits 11:4, low upper nibble bits 3:0.
// RQ8: Right layout: high byte bits 7:4 read zero.
// RQ9: Channel 1 uses offsets 0x1a and 0x1b; channel 0 low is 0x18.
// RQ10: Left layout: writing only the high byte gives an 8-bit conversion; the code takes bits 3:0 from the shared temp_byte.
// RQ11: Software writes zero to reserved bits, which read zero.
// RQ12: Gain trim at 0x08 is read/write, resets to zero.
// RQ13: Offset trim at 0x09 is read/write, resets to zero.
// RQ14: Left-align control is bit 0 of the third control register.
// RQ15: Channel 1 empty flag at status bit 1 behaves like channel 0.
// RQ16: Low byte waits in a temporary register; high byte commits both.
// RQ17: Value and trim registers reset to zero, right layout after reset.
`timescale 1ns/1ps
module dac_data_calibration_regs
    import dac_data_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // Register port.
    input  wire logic [ADDR_WIDTH-1:0]  reg_addr,
    input  wire logic [DATA_WIDTH-1:0]  reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [DATA_WIDTH-1:0]  reg_rdata,
    // Converter side.
    input  wire logic [CHAN_COUNT-1:0]  conv_take,
    output logic      [VALUE_WIDTH-1:0] chan0_value,
    output logic      [VALUE_WIDTH-1:0] chan1_value,
    output logic      [DATA_WIDTH-1:0]  gain_trim_out,
    output logic      [DATA_WIDTH-1:0]  offset_trim_out,
    // Requests.
    output logic      [CHAN_COUNT-1:0]  dma_request,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Control, trim and temporary registers.

    logic                  left_align_select;
    logic [DATA_WIDTH-1:0] gain_trim;
    logic [DATA_WIDTH-1:0] offset_trim;
    logic [DATA_WIDTH-1:0] temp_byte;
    logic [CHAN_COUNT-1:0] empty_flag;
    logic [CHAN_COUNT-1:0] irq_status;
    logic [CHAN_COUNT-1:0] irq_mask;
    logic [CHAN_COUNT-1:0] high_write;
    logic [CHAN_COUNT-1:0] low_write;
    logic [VALUE_WIDTH-1:0] value [CHAN_COUNT];
    logic [VALUE_WIDTH-1:0] next_value [CHAN_COUNT];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            left_align_select <= 1'b0; // RQ17
        end else if (reg_write && reg_addr == OFS_CONTROL_C) begin
            left_align_select <= reg_wdata[LEFT_ALIGN_BIT]; // RQ6 RQ14
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gain_trim   <= BYTE_RESET; // RQ17
            offset_trim <= BYTE_RESET;
        end else if (reg_write) begin
            if (reg_addr == OFS_GAIN_TRIM) begin
                gain_trim <= reg_wdata; // RQ12
            end else if (reg_addr == OFS_OFFSET_TRIM) begin
                offset_trim <= reg_wdata; // RQ13
            end
        end
    end

    assign low_write[0]  = reg_write && reg_addr == OFS_CHAN0_LOW;
    assign low_write[1]  = reg_write && reg_addr == OFS_CHAN1_LOW; // RQ9
    assign high_write[0] = reg_write && reg_addr == OFS_CHAN0_HIGH;
    assign high_write[1] = reg_write && reg_addr == OFS_CHAN1_HIGH; // RQ9

    // One temporary byte is shared by both channels, so interleaved pairs corrupt.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            temp_byte <= BYTE_RESET;
        end else if (|low_write) begin
            temp_byte <= reg_wdata; // RQ16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Value assembly and empty flags, one per channel.

    genvar ch;
    generate
        for (ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
            always_comb begin
                if (left_align_select) begin
                    next_value[ch] = {reg_wdata, temp_byte[7:4]}; // RQ7 RQ10
                end else begin
                    next_value[ch] = {reg_wdata[3:0], temp_byte}; // RQ5 RQ11
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    value[ch] <= VALUE_RESET; // RQ17
                end else if (high_write[ch]) begin
                    value[ch] <= next_value[ch]; // RQ2 RQ4 RQ16
                end
            end

            // A commit beats a take in the same cycle, so new data stay pending.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    empty_flag[ch] <= 1'b0;
                end else if (high_write[ch]) begin
                    empty_flag[ch] <= 1'b0; // RQ16
                end else if (conv_take[ch]) begin
                    empty_flag[ch] <= 1'b1; // RQ1 RQ15
                end
            end

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    irq_status[ch] <= 1'b0;
                end else if (conv_take[ch] && !high_write[ch]) begin
                    irq_status[ch] <= 1'b1;
                end else if (reg_write && reg_addr == OFS_IRQ_STATUS && reg_wdata[ch]) begin
                    irq_status[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_mask <= FLAGS_RESET;
        end else if (reg_write && reg_addr == OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[CHAN_COUNT-1:0];
        end
    end

    assign chan0_value     = value[0];
    assign chan1_value     = value[1];
    assign gain_trim_out   = gain_trim;
    assign offset_trim_out = offset_trim;
    assign dma_request     = empty_flag; // RQ3 RQ15
    assign irq             = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read-back.

    function automatic logic [7:0] high_view(input logic [11:0] v, input logic left);
        high_view = left ? v[11:4] : {4'h0, v[11:8]}; // RQ7 RQ8
    endfunction

    function automatic logic [7:0] low_view(input logic [11:0] v, input logic left);
        low_view = left ? {v[3:0], 4'h0} : v[7:0]; // RQ5 RQ11
    endfunction

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= BYTE_RESET;
        end else if (reg_read) begin
            if (reg_addr == OFS_CONTROL_C) begin
                reg_rdata <= {7'h00, left_align_select};
            end else if (reg_addr == OFS_STATUS) begin
                reg_rdata <= {6'h00, empty_flag}; // RQ1 RQ15
            end else if (reg_addr == OFS_IRQ_MASK) begin
                reg_rdata <= {6'h00, irq_mask};
            end else if (reg_addr == OFS_IRQ_STATUS) begin
                reg_rdata <= {6'h00, irq_status};
            end else if (reg_addr == OFS_GAIN_TRIM) begin
                reg_rdata <= gain_trim;
            end else if (reg_addr == OFS_OFFSET_TRIM) begin
                reg_rdata <= offset_trim;
            end else if (reg_addr == OFS_CHAN0_LOW) begin
                reg_rdata <= low_view(value[0], left_align_select);
            end else if (reg_addr == OFS_CHAN0_HIGH) begin
                reg_rdata <= high_view(value[0], left_align_select);
            end else if (reg_addr == OFS_CHAN1_LOW) begin
                reg_rdata <= low_view(value[1], left_align_select);
            end else if (reg_addr == OFS_CHAN1_HIGH) begin
                reg_rdata <= high_view(value[1], left_align_select);
            end else begin
                reg_rdata <= BYTE_RESET;
            end
        end else begin
            reg_rdata <= BYTE_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_empty_set_take: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
        conv_take[0] && !high_write[0] |=> empty_flag[0])
        else $error("channel 0 empty flag not set after take");

    a_overwrite_value: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ2
        high_write[0] && !empty_flag[0] && !left_align_select
        |=> chan0_value == {$past(reg_wdata[3:0]), $past(temp_byte)})
        else $error("pending value not overwritten");

    a_dma_follow_flag: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
        $rose(dma_request[0]) |-> $past(conv_take[0]))
        else $error("channel 0 dma request rose without take");

    a_right_pair_commit: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ5
        low_write[0] && !left_align_select ##1 !(|low_write) ##1
        high_write[0] && !left_align_select
        |=> chan0_value == {$past(reg_wdata[3:0]), $past(reg_wdata, 3)})
        else $error("right layout value assembled wrongly");

    a_left_high_only: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
        high_write[0] && left_align_select && temp_byte == 8'h00
        |=> chan0_value == {$past(reg_wdata), 4'h0})
        else $error("left layout 8-bit conversion wrong");

    a_high_reserved: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ8
        reg_read && reg_addr == OFS_CHAN1_HIGH && !left_align_select
        |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(value[1][11:8]))
        else $error("right layout high byte read wrong");

    a_gain_readback: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ12
        reg_read && reg_addr == OFS_GAIN_TRIM |=> reg_rdata == $past(gain_trim))
        else $error("gain trim readback wrong");

    a_offset_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ13
        !(reg_write && reg_addr == OFS_OFFSET_TRIM) |=> $stable(offset_trim))
        else $error("offset trim changed without write");

    a_commit_clears: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ16
        high_write[1] |=> !empty_flag[1] && !dma_request[1])
        else $error("channel 1 commit did not clear empty flag");

    a_left_select: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ14
        reg_write && reg_addr == OFS_CONTROL_C
        |=> left_align_select == $past(reg_wdata[LEFT_ALIGN_BIT]))
        else $error("left align select not updated");

    ////////////////////////////////////////////////////////////////////////
    // Empty flags and DMA requests.

    a_empty1_set_take: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ15
        conv_take[1] && !high_write[1] |=> empty_flag[1])
        else $error("channel 1 empty flag not set after take");

    a_empty0_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
        empty_flag[0] && !high_write[0] |=> empty_flag[0])
        else $error("channel 0 empty flag dropped without commit");

    a_empty1_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ15
        empty_flag[1] && !high_write[1] |=> empty_flag[1])
        else $error("channel 1 empty flag dropped without commit");

    a_commit0_clears: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ16
        high_write[0] |=> !empty_flag[0] && !dma_request[0])
        else $error("channel 0 commit did not clear empty flag");

    a_flag0_fall_cause: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ16
        $fell(empty_flag[0]) |-> $past(high_write[0]))
        else $error("channel 0 empty flag fell without commit");

    a_dma1_rise_cause: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3 RQ15
        $rose(dma_request[1]) |-> $past(conv_take[1]))
        else $error("channel 1 dma request rose without take");

    a_dma1_fall_cause: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3 RQ15
        $fell(dma_request[1]) |-> $past(high_write[1]))
        else $error("channel 1 dma request fell without commit");

    a_status_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ15
        reg_read && reg_addr == OFS_STATUS |=> reg_rdata == {6'h00, $past(empty_flag)})
        else $error("status read does not show empty flags");

    ////////////////////////////////////////////////////////////////////////
    // Value commits in both layouts.

    a_temp_capture: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ16
        (|low_write) |=> temp_byte == $past(reg_wdata))
        else $error("low byte not held in temporary register");

    a_value0_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ4
        !high_write[0] |=> $stable(chan0_value))
        else $error("channel 0 value changed without commit");

    a_value1_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ4
        !high_write[1] |=> $stable(chan1_value))
        else $error("channel 1 value changed without commit");

    a_overwrite_chan1: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ2
        high_write[1] && !empty_flag[1] && !left_align_select
        |=> chan1_value == {$past(reg_wdata[3:0]), $past(temp_byte)})
        else $error("channel 1 pending value not overwritten");

    a_left_chan0_commit: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
        high_write[0] && left_align_select
        |=> chan0_value == {$past(reg_wdata), $past(temp_byte[7:4])})
        else $error("channel 0 left layout value assembled wrongly");

    a_left_chan1_commit: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ9
        high_write[1] && left_align_select
        |=> chan1_value == {$past(reg_wdata), $past(temp_byte[7:4])})
        else $error("channel 1 left layout value assembled wrongly");

    a_left_high_only1: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
        high_write[1] && left_align_select && temp_byte == 8'h00
        |=> chan1_value == {$past(reg_wdata), 4'h0})
        else $error("channel 1 left layout 8-bit conversion wrong");

    a_right_high_nibble: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ5
        high_write[0] && !left_align_select |=> chan0_value[11:8] == $past(reg_wdata[3:0]))
        else $error("right layout high nibble not committed");

    ////////////////////////////////////////////////////////////////////////
    // Read-back views.

    a_right_low_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ5
        reg_read && reg_addr == OFS_CHAN0_LOW && !left_align_select
        |=> reg_rdata == $past(chan0_value[7:0]))
        else $error("right layout low byte read wrong");

    a_left_low_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
        reg_read && reg_addr == OFS_CHAN0_LOW && left_align_select
        |=> reg_rdata == {$past(chan0_value[3:0]), 4'h0})
        else $error("left layout low byte read wrong");

    a_left_high_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
        reg_read && reg_addr == OFS_CHAN0_HIGH && left_align_select
        |=> reg_rdata == $past(chan0_value[11:4]))
        else $error("left layout high byte read wrong");

    a_right_high_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ8
        reg_read && reg_addr == OFS_CHAN0_HIGH && !left_align_select
        |=> reg_rdata == {4'h0, $past(chan0_value[11:8])})
        else $error("right layout channel 0 high byte read wrong");

    a_chan1_low_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ9
        reg_read && reg_addr == OFS_CHAN1_LOW && !left_align_select
        |=> reg_rdata == $past(chan1_value[7:0]))
        else $error("channel 1 low byte read wrong");

    a_chan1_left_high: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ9
        reg_read && reg_addr == OFS_CHAN1_HIGH && left_align_select
        |=> reg_rdata == $past(chan1_value[11:4]))
        else $error("channel 1 left layout high byte read wrong");

    a_control_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ14
        reg_read && reg_addr == OFS_CONTROL_C
        |=> reg_rdata == {7'h00, $past(left_align_select)})
        else $error("control register read wrong");

    ////////////////////////////////////////////////////////////////////////
    // Trim and control registers.

    a_gain_write: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ12
        reg_write && reg_addr == OFS_GAIN_TRIM |=> gain_trim_out == $past(reg_wdata))
        else $error("gain trim write not taken");

    a_offset_write: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ13
        reg_write && reg_addr == OFS_OFFSET_TRIM |=> offset_trim_out == $past(reg_wdata))
        else $error("offset trim write not taken");

    a_offset_readback: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ13
        reg_read && reg_addr == OFS_OFFSET_TRIM |=> reg_rdata == $past(offset_trim))
        else $error("offset trim readback wrong");

    a_gain_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ12
        !(reg_write && reg_addr == OFS_GAIN_TRIM) |=> $stable(gain_trim))
        else $error("gain trim changed without write");

    a_left_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ6
        !(reg_write && reg_addr == OFS_CONTROL_C) |=> $stable(left_align_select))
        else $error("left align select changed without write");

endmodule // dac_data_calibration_regs

//--- bench/converter_model.sv
// Converter model: takes a channel's committed value after a commanded delay.
// Assumes the bench pulses take_cmd for one cycle per take.
`timescale 1ns/1ps
module converter_model (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Command from the bench.
    input  wire logic [1:0] take_cmd,
    input  wire logic [3:0] take_delay,
    // Converter side.
    output logic      [1:0] conv_take
);
    logic [1:0] pend;
    logic [3:0] cnt;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend      <= 2'h0;
            cnt       <= 4'h0;
            conv_take <= 2'h0;
        end else if (take_cmd != 2'h0) begin
            pend      <= take_cmd;
            cnt       <= take_delay;
            conv_take <= 2'h0;
        end else begin
            conv_take <= (cnt == 4'h0) ? pend : 2'h0;
            if (cnt == 4'h0) pend <= 2'h0;
            else cnt <= cnt - 4'h1;
        end
    end
endmodule // converter_model

//--- bench/dac_data_calibration_regs_tb.sv
// Self-checking bench for the converter data and calibration registers.
// Assumes the design package and a converter model that pulses conv_take.
`timescale 1ns/1ps
module dac_data_calibration_regs_tb;
    import dac_data_pkg::*;
    logic                   clk_sys, rstn, reg_write, reg_read, irq;
    logic [ADDR_WIDTH-1:0]  reg_addr;
    logic [DATA_WIDTH-1:0]  reg_wdata, reg_rdata, gain_trim_out, offset_trim_out, rd, g;
    logic [VALUE_WIDTH-1:0] chan0_value, chan1_value, x;
    logic [CHAN_COUNT-1:0]  conv_take, dma_request, take_cmd;
    logic [3:0]             take_delay;
    logic                   left;
    int                     n_errors, num_checks, ch;
    dac_data_calibration_regs uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .conv_take(conv_take), .chan0_value(chan0_value),
        .chan1_value(chan1_value), .gain_trim_out(gain_trim_out),
        .offset_trim_out(offset_trim_out), .dma_request(dma_request), .irq(irq));
    converter_model partner (.clk_sys(clk_sys), .rstn(rstn), .take_cmd(take_cmd),
        .take_delay(take_delay), .conv_take(conv_take));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] low_of(logic [11:0] v, logic l);
        return l ? {v[3:0], 4'h0} : v[7:0];
    endfunction
    function automatic logic [7:0] high_of(logic [11:0] v, logic l);
        return l ? v[11:4] : {4'h0, v[11:8]};
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
        chk({4'h0, rd}, {4'h0, exp});
    endtask
    task automatic load(input int c, input logic [11:0] v, input logic l);
        wr(c ? OFS_CHAN1_LOW : OFS_CHAN0_LOW, low_of(v, l));
        wr(c ? OFS_CHAN1_HIGH : OFS_CHAN0_HIGH, high_of(v, l));
        chk(c ? chan1_value : chan0_value, v);
        chk({11'h0, dma_request[c]}, 12'h0);
        rdc(c ? OFS_CHAN1_LOW : OFS_CHAN0_LOW, low_of(v, l));
        rdc(c ? OFS_CHAN1_HIGH : OFS_CHAN0_HIGH, high_of(v, l));
    endtask
    task automatic take(input int c);
        @(posedge clk_sys);
        take_cmd   <= 2'(1 << c);
        take_delay <= 4'($urandom_range(0, 9));
        @(posedge clk_sys);
        take_cmd <= 2'h0;
        repeat (14) @(posedge clk_sys);
        #1;
        chk({11'h0, dma_request[c]}, 12'h1);
        chk({11'h0, irq}, (c == 0) ? 12'h1 : 12'h0);
        rdc(OFS_STATUS, 8'(1 << c));
        chk({11'h0, rd[c]}, 12'h1);
    endtask
    task automatic final_report;
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        {reg_write, reg_read, reg_addr, reg_wdata, take_cmd, take_delay} = '0;
        void'($urandom(32'ha6bc1d3d));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(OFS_GAIN_TRIM, 8'h00);
        rdc(OFS_OFFSET_TRIM, 8'h00);
        rdc(OFS_CHAN0_HIGH, 8'h00);
        rdc(OFS_CHAN1_LOW, 8'h00);
        rdc(OFS_CONTROL_C, 8'h00);
        rdc(5'h1f, 8'h00);
        for (int i = 0; i < 4; i++) begin
            g = 8'($urandom);
            wr(OFS_GAIN_TRIM, g);
            wr(OFS_OFFSET_TRIM, ~g);
            rdc(OFS_GAIN_TRIM, g);
            rdc(OFS_OFFSET_TRIM, ~g);
            chk({4'h0, gain_trim_out ^ offset_trim_out}, 12'h0ff);
        end
        wr(OFS_IRQ_MASK, 8'h01);
        for (int i = 0; i < 8; i++) begin
            ch = i % 2;
            left = (i >= 4);
            if (i == 4) wr(OFS_CONTROL_C, 8'h01);
            if (i == 4) rdc(OFS_CHAN1_HIGH, high_of(x, 1'b1));
            take(ch);
            wr(OFS_IRQ_STATUS, 8'h03);
            chk({11'h0, irq}, 12'h0);
            x = (i == 0) ? 12'hfff : 12'($urandom);
            load(ch, x, left);
            x = 12'($urandom);
            load(ch, x, left);
            rdc(OFS_CONTROL_C, 8'(left));
        end
        for (int c = 0; c < 2; c++) begin
            wr(c ? OFS_CHAN1_LOW : OFS_CHAN0_LOW, 8'h00);
            g = 8'($urandom);
            wr(c ? OFS_CHAN1_HIGH : OFS_CHAN0_HIGH, g);
            chk(c ? chan1_value : chan0_value, {g, 4'h0});
            rdc(c ? OFS_CHAN1_HIGH : OFS_CHAN0_HIGH, g);
        end
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        chk(chan1_value, VALUE_RESET);
        chk({4'h0, gain_trim_out | offset_trim_out}, 12'h000);
        chk({10'h0, dma_request}, 12'h000);
        rdc(OFS_CONTROL_C, 8'h00);
        rdc(OFS_CHAN0_HIGH, 8'h00);
        final_report();
    end
endmodule // dac_data_calibration_regs_tb
